//--- rtl/vpm_regs.svh
// Register offsets, field positions, reset values and run lengths
// Assumes the byte wide microprocessor port of the path overhead monitor
`ifndef VPM_REGS_SVH
`define VPM_REGS_SVH
`define VPM_GLB_SDH      10'h007
`define VPM_GLB_DEB      10'h01E
`define VPM_CH_BASE      10'h040
`define VPM_LABEL_CFG    8'h07
`define VPM_MASK1        8'h09
`define VPM_MASK2        8'h0A
`define VPM_STAT1        8'h11
`define VPM_STAT2        8'h12
`define VPM_EVT1         8'h15
`define VPM_EVT2         8'h16
`define VPM_PERF1        8'h19
`define VPM_PERF2        8'h1A
`define VPM_FLT1         8'h1D
`define VPM_FLT2         8'h1E
`define VPM_RXLABEL      8'h20
`define VPM_BIP_A        8'h26
`define VPM_BIP_B        8'h27
`define VPM_REI_A        8'h28
`define VPM_REI_B        8'h29
`define VPM_BIP_SH_A     8'h2E
`define VPM_BIP_SH_B     8'h2F
`define VPM_REI_SH_A     8'h30
`define VPM_REI_SH_B     8'h31
`define VPM_SDH_BIT      5
`define VPM_DEB_BIT      0
`define VPM_RST_BYTE     8'h00
`define VPM_LBL_UNEQ     3'h0
`define VPM_LBL_NONSPEC  3'h1
`define VPM_LBL_ASYNC    3'h2
`define VPM_LBL_BSYNC    3'h4
`define VPM_ERDI_PAY     3'h2
`define VPM_ERDI_SRV     3'h5
`define VPM_ERDI_CON     3'h6
`define VPM_RUN_SHORT    4'h5
`define VPM_RUN_LONG     4'hA
`define VPM_CNT_MAX      12'hFFF
`endif

//--- rtl/vpm_pkg.sv
// Types shared by the path overhead monitor
// Assumes the constants header is included by users of the offsets
package vpm_pkg;
    // One superframe worth of dropped overhead
    typedef struct packed {
        logic       valid;
        logic [7:0] v5;
        logic [7:0] z7;
        logic [1:0] bip_calc;
    } vpm_ovh_t;
    // Microprocessor request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [9:0] addr;
        logic [7:0] wdata;
    } vpm_cpu_t;
endpackage : vpm_pkg

//--- rtl/vpm_monitor.sv
// Receive VT1.5/TU-11 path overhead monitor for one demapper channel
// Assumes overhead strobes from telecom bus termination on mclk
`timescale 1ns/10ps
`include "vpm_regs.svh"
module vpm_monitor (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire vpm_pkg::vpm_ovh_t ovh,
    input  wire vpm_pkg::vpm_cpu_t cpu,
    input  wire logic             signal_fail_input,
    input  wire logic             perf_tick,
    input  wire logic             byte_sync_mode,
    output logic [7:0]            cpu_rdata,
    output logic                  cpu_rvalid,
    output logic [2:0]            tx_label,
    output logic                  rfi_yellow
);
    localparam int N = 6;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] sf_sync;
    logic [1:0] tk_sync;
    logic       tk_prev;
    logic       sf;
    logic       tick;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sf_sync <= 2'h0;
            tk_sync <= 2'h0;
            tk_prev <= 1'b0;
        end else begin
            sf_sync <= {sf_sync[0], signal_fail_input};
            tk_sync <= {tk_sync[0], perf_tick};
            tk_prev <= tk_sync[1];
        end
    end
    assign sf   = sf_sync[1];
    assign tick = tk_sync[1] & ~tk_prev;

    ////////////////////////////////////////////////////////////////////
    // Register writes
    logic       ch_hit;
    logic [7:0] off;
    logic [7:0] lbl_cfg;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic       sdh_mode;
    logic       rdi_long_debounce;
    assign ch_hit = cpu.addr[9:6] == 4'(`VPM_CH_BASE >> 6);
    assign off    = {2'h0, cpu.addr[5:0]};

    // Configuration registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lbl_cfg           <= `VPM_RST_BYTE;
            mask1             <= `VPM_RST_BYTE;
            mask2             <= `VPM_RST_BYTE;
            sdh_mode          <= 1'b0;
            rdi_long_debounce <= 1'b0;
        end else if (cpu.wr) begin
            if (cpu.addr == `VPM_GLB_SDH)
                sdh_mode <= cpu.wdata[`VPM_SDH_BIT];
            if (cpu.addr == `VPM_GLB_DEB)
                rdi_long_debounce <= cpu.wdata[`VPM_DEB_BIT];
            if (ch_hit && off == `VPM_LABEL_CFG)
                lbl_cfg <= cpu.wdata & 8'h77;
            if (ch_hit && off == `VPM_MASK1)
                mask1 <= cpu.wdata;
            if (ch_hit && off == `VPM_MASK2)
                mask2 <= {5'h00, cpu.wdata[2:0]};
        end
    end

    logic [2:0] exp_label;
    assign exp_label = lbl_cfg[6:4];
    assign tx_label  = lbl_cfg[2:0];

    ////////////////////////////////////////////////////////////////////
    // Overhead decode
    logic [2:0] rx_in;
    logic [2:0] z7_code;
    logic       enhanced;
    logic       mis_raw;
    logic [N-1:0] raw;
    logic [N-1:0] clr;
    logic [3:0] rdi_run;
    logic [3:0] thr [N];
    assign rx_in    = ovh.v5[3:1];
    assign z7_code  = ovh.z7[3:1];
    assign enhanced = ovh.z7[2] ^ ovh.z7[1];

    // Mismatch test, nonspecific and unequipped exceptions
    assign mis_raw = (rx_in != `VPM_LBL_UNEQ) && (rx_in != exp_label)
        && !(rx_in == `VPM_LBL_NONSPEC && exp_label != `VPM_LBL_UNEQ)
        && (exp_label != `VPM_LBL_NONSPEC);

    // Raw per-frame conditions: rdi, rfi, payload, server, conn, mismatch
    assign raw[0] = !enhanced && ovh.v5[0];
    assign raw[1] = ovh.v5[4];
    assign raw[2] = enhanced && z7_code == `VPM_ERDI_PAY;
    assign raw[3] = enhanced && z7_code == `VPM_ERDI_SRV;
    assign raw[4] = enhanced && z7_code == `VPM_ERDI_CON;
    assign raw[5] = mis_raw;
    assign clr    = {1'b0, {3{sf}}, 1'b0, sf};

    // Run lengths
    assign rdi_run = rdi_long_debounce ? `VPM_RUN_LONG : `VPM_RUN_SHORT;
    assign thr[0]  = rdi_run;
    assign thr[1]  = `VPM_RUN_LONG;
    assign thr[2]  = rdi_run;
    assign thr[3]  = rdi_run;
    assign thr[4]  = rdi_run;
    assign thr[5]  = `VPM_RUN_SHORT;

    ////////////////////////////////////////////////////////////////////
    // Persistency filters
    logic [N-1:0] st;
    logic [3:0]   dcnt [N];
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_deb
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    st[gi]   <= 1'b0;
                    dcnt[gi] <= 4'h0;
                end else if (clr[gi]) begin
                    st[gi]   <= 1'b0;
                    dcnt[gi] <= 4'h0;
                end else if (ovh.valid) begin
                    if (raw[gi] == st[gi]) begin
                        dcnt[gi] <= 4'h0;
                    end else if (dcnt[gi] + 4'h1 >= thr[gi]) begin
                        st[gi]   <= raw[gi];
                        dcnt[gi] <= 4'h0;
                    end else begin
                        dcnt[gi] <= dcnt[gi] + 4'h1;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Received label and unequipped
    logic [2:0] rx_label;
    logic       uneq;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_label <= 3'h0;
            uneq     <= 1'b0;
        end else if (ovh.valid) begin
            rx_label <= rx_in;
            uneq     <= rx_in == `VPM_LBL_UNEQ;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Error counters
    logic [1:0]  bip_diff;
    logic [1:0]  bip_inc;
    logic [12:0] bip_sum;
    logic [12:0] rei_sum;
    logic [11:0] bip_cnt;
    logic [11:0] rei_cnt;
    logic [11:0] bip_sh;
    logic [11:0] rei_sh;
    logic        bip_ov;
    logic        rei_ov;
    assign bip_diff = ovh.v5[7:6] ^ ovh.bip_calc;
    assign bip_inc  = !ovh.valid ? 2'h0
                    : sdh_mode ? {1'b0, |bip_diff}
                    : {1'b0, bip_diff[1]} + {1'b0, bip_diff[0]};
    assign bip_sum  = {1'b0, tick ? 12'h000 : bip_cnt} + {11'h000, bip_inc};
    assign rei_sum  = {1'b0, tick ? 12'h000 : rei_cnt}
                    + {12'h000, ovh.valid & ovh.v5[5]};

    // Saturating counts, shadows taken on the tick
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bip_cnt <= 12'h000;
            rei_cnt <= 12'h000;
            bip_sh  <= 12'h000;
            rei_sh  <= 12'h000;
            bip_ov  <= 1'b0;
            rei_ov  <= 1'b0;
        end else begin
            bip_cnt <= bip_sum[12] ? `VPM_CNT_MAX : bip_sum[11:0];
            rei_cnt <= rei_sum[12] ? `VPM_CNT_MAX : rei_sum[11:0];
            bip_ov  <= bip_sum[12] | (bip_ov & ~tick);
            rei_ov  <= rei_sum[12] | (rei_ov & ~tick);
            if (tick) begin
                bip_sh <= bip_cnt;
                rei_sh <= rei_cnt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status, events, performance and hard fault
    logic [7:0]  stat1;
    logic [7:0]  stat2;
    logic [15:0] st_all;
    logic [15:0] st_prev;
    logic [15:0] evt;
    logic [15:0] evt_clr;
    logic [15:0] perf_acc;
    logic [15:0] flt_acc;
    logic [15:0] perf;
    logic [15:0] flt;
    logic        srv;
    logic        con;
    logic        pay;
    assign srv   = st[3];
    assign con   = st[4] & ~st[3];
    assign pay   = st[2] & ~st[3] & ~st[4];
    assign stat1 = {rei_ov, bip_ov, 2'h0, st[1], uneq, st[5], st[0]};
    assign stat2 = {5'h00, pay, srv, con};
    assign st_all = {stat2, stat1};
    assign evt_clr = {cpu.rd && ch_hit && off == `VPM_EVT2 ? 8'hFF : 8'h00,
                      cpu.rd && ch_hit && off == `VPM_EVT1 ? 8'hFF : 8'h00};

    // Change latches, set wins over read clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_prev <= 16'h0000;
            evt     <= 16'h0000;
        end else begin
            st_prev <= st_all;
            evt     <= (evt & ~evt_clr) | (st_all ^ st_prev);
        end
    end

    // Per-interval seen and held summaries
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            perf_acc <= 16'h0000;
            flt_acc  <= 16'hFFFF;
            perf     <= 16'h0000;
            flt      <= 16'h0000;
        end else if (tick) begin
            perf     <= perf_acc | st_all;
            flt      <= flt_acc & st_all;
            perf_acc <= 16'h0000;
            flt_acc  <= 16'hFFFF;
        end else begin
            perf_acc <= perf_acc | st_all;
            flt_acc  <= flt_acc & st_all;
        end
    end

    // Yellow forwarding
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            rfi_yellow <= 1'b0;
        else
            rfi_yellow <= st[1] & byte_sync_mode;
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (cpu.addr == `VPM_GLB_SDH)
            next_rdata = {2'h0, sdh_mode, 5'h00};
        else if (cpu.addr == `VPM_GLB_DEB)
            next_rdata = {7'h00, rdi_long_debounce};
        else if (ch_hit) begin
            case (off)
                `VPM_LABEL_CFG: next_rdata = lbl_cfg;
                `VPM_MASK1:     next_rdata = mask1;
                `VPM_MASK2:     next_rdata = mask2;
                `VPM_STAT1:     next_rdata = stat1;
                `VPM_STAT2:     next_rdata = stat2;
                `VPM_EVT1:      next_rdata = evt[7:0];
                `VPM_EVT2:      next_rdata = evt[15:8];
                `VPM_PERF1:     next_rdata = perf[7:0];
                `VPM_PERF2:     next_rdata = perf[15:8];
                `VPM_FLT1:      next_rdata = flt[7:0];
                `VPM_FLT2:      next_rdata = flt[15:8];
                `VPM_RXLABEL:   next_rdata = {5'h00, rx_label};
                `VPM_BIP_A:     next_rdata = bip_cnt[7:0];
                `VPM_BIP_B:     next_rdata = {4'h0, bip_cnt[11:8]};
                `VPM_REI_A:     next_rdata = rei_cnt[7:0];
                `VPM_REI_B:     next_rdata = {4'h0, rei_cnt[11:8]};
                `VPM_BIP_SH_A:  next_rdata = bip_sh[7:0];
                `VPM_BIP_SH_B:  next_rdata = {4'h0, bip_sh[11:8]};
                `VPM_REI_SH_A:  next_rdata = rei_sh[7:0];
                `VPM_REI_SH_B:  next_rdata = {4'h0, rei_sh[11:8]};
                default:        next_rdata = 8'h00;
            endcase
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpu_rdata  <= 8'h00;
            cpu_rvalid <= 1'b0;
        end else begin
            cpu_rvalid <= cpu.rd;
            if (cpu.rd)
                cpu_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_label;
        ovh.valid |=> rx_label == $past(ovh.v5[3:1]);
    endproperty
    a_label: assert property (p_label) else $error("label not captured");

    property p_mis_run;
        $changed(st[5]) |-> $past(dcnt[5]) == 4'h4 && $past(ovh.valid);
    endproperty
    a_mis_run: assert property (p_mis_run) else $error("mismatch run wrong");

    property p_nonspec;
        ovh.valid && rx_in == `VPM_LBL_NONSPEC && exp_label != `VPM_LBL_UNEQ
            && !st[5] |=> dcnt[5] == 4'h0 && !st[5];
    endproperty
    a_nonspec: assert property (p_nonspec) else $error("001 counted");

    property p_uneq;
        ovh.valid && rx_in == `VPM_LBL_UNEQ |=> uneq ##0 stat1[2];
    endproperty
    a_uneq: assert property (p_uneq) else $error("unequipped missed");

    property p_rdi_run;
        $changed(st[0]) && !$past(sf) |->
            $past(dcnt[0]) == ($past(rdi_long_debounce) ? 4'h9 : 4'h4);
    endproperty
    a_rdi_run: assert property (p_rdi_run) else $error("rdi run wrong");

    property p_rfi_run;
        $changed(st[1]) |-> $past(dcnt[1]) == 4'h9;
    endproperty
    a_rfi_run: assert property (p_rfi_run) else $error("rfi run wrong");

    property p_sf;
        sf |=> !st[0] && stat2 == 8'h00;
    endproperty
    a_sf: assert property (p_sf) else $error("rdi not suppressed");

    property p_bip_blk;
        ovh.valid && sdh_mode && bip_diff == 2'h3 && !tick
            && bip_cnt < 12'hFF0 |=> bip_cnt == $past(bip_cnt) + 12'h001;
    endproperty
    a_bip_blk: assert property (p_bip_blk) else $error("block count wrong");

    property p_prio;
        !(stat2[1] && (stat2[0] || stat2[2])) && !(stat2[0] && stat2[2]);
    endproperty
    a_prio: assert property (p_prio) else $error("defect priority");

    property p_evt;
        $rose(uneq) |=> evt[2];
    endproperty
    a_evt: assert property (p_evt) else $error("event not latched");

    // Yellow follows the declared far end fail only in byte-synchronous mode
    property p_yellow;
        rfi_yellow == ($past(st[1]) && $past(byte_sync_mode));
    endproperty
    a_yellow: assert property (p_yellow) else $error("yellow forwarding wrong");

    // A carry out of the parity count pins it at full scale with overflow
    property p_bip_sat;
        $past(bip_sum[12]) |-> bip_cnt == `VPM_CNT_MAX && bip_ov;
    endproperty
    a_bip_sat: assert property (p_bip_sat) else $error("parity count not saturated");

    c_mis: cover property ($rose(st[5]));
    c_rdi: cover property ($rose(st[0]));
    c_srv: cover property ($rose(stat2[1]));
    c_bip_ov: cover property ($rose(bip_ov));
endmodule : vpm_monitor

//--- testbench/vpm_bus_model.sv
// Far side model: telecom bus termination handing over dropped overhead
// Assumes callers enter send just after a rising mclk edge
`timescale 1ns/10ps
module vpm_bus_model (
    input  wire logic         mclk,
    output vpm_pkg::vpm_ovh_t ovh
);
    ////////////////////////////////////////////////////////////////////////////
    // Idle lines start low
    initial begin
        ovh = '0;
    end

    // One superframe strobe, then a cycle of inverted data so stale bytes never pass
    task automatic send(input logic [7:0] v5, input logic [7:0] z7, input logic [1:0] bip);
        ovh = '{1'b1, v5, z7, bip};
        @(posedge mclk);
        #1 ovh = '{1'b0, ~v5, ~z7, ~bip};
        @(posedge mclk);
        #1;
    endtask : send
endmodule : vpm_bus_model

//--- testbench/testbench.sv
// Self-checking bench for the path overhead monitor
// Assumes the bus model drives overhead; cpu port driven here
`timescale 1ns/10ps
module testbench;
    typedef struct packed {
        logic [7:0] v5;
        logic [9:0] addr;
        logic [7:0] exp;
    } vpm_row_t;

    logic              mclk = 1'b0;
    logic              rst = 1'b1;
    vpm_pkg::vpm_ovh_t ovh;
    vpm_pkg::vpm_cpu_t cpu = '0;
    logic              signal_fail_input = 1'b0;
    logic              perf_tick = 1'b0;
    logic              byte_sync_mode = 1'b0;
    logic [7:0]        cpu_rdata;
    logic              cpu_rvalid;
    logic [2:0]        tx_label;
    logic              rfi_yellow;
    int                bad_count = 0;
    int                compares = 0;
    // Frame label rows: v5 in, register read, expected byte
    vpm_row_t          rows [4] = '{'{8'h04, 10'h060, 8'h02}, '{8'h00, 10'h051, 8'h04},
                                    '{8'h0E, 10'h060, 8'h07}, '{8'h08, 10'h060, 8'h04}};
    // Enhanced rows: z7 in the first field, second status, expected byte
    vpm_row_t          erdi [3] = '{'{8'h0A, 10'h052, 8'h02}, '{8'h0C, 10'h052, 8'h01},
                                    '{8'h04, 10'h052, 8'h04}};

    ////////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    always #20 mclk = ~mclk;

    vpm_monitor i_dut (
        .mclk              (mclk),
        .rst               (rst),
        .ovh               (ovh),
        .cpu               (cpu),
        .signal_fail_input (signal_fail_input),
        .perf_tick         (perf_tick),
        .byte_sync_mode    (byte_sync_mode),
        .cpu_rdata         (cpu_rdata),
        .cpu_rvalid        (cpu_rvalid),
        .tx_label          (tx_label),
        .rfi_yellow        (rfi_yellow)
    );

    vpm_bus_model i_bus (
        .mclk (mclk),
        .ovh  (ovh)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic conclude();
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // Step to just after the next rising edge
    task automatic cyc();
        @(posedge mclk);
        #1;
    endtask : cyc

    // Counted comparison
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // One cycle write strobe
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        cpu = '{1'b1, 1'b0, a, d};
        cyc();
        cpu = '0;
        cyc();
    endtask : wr

    // Read strobe, bounded wait for the answer pulse, masked compare
    task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        int n;
        cpu = '{1'b0, 1'b1, a, 8'h00};
        cyc();
        cpu = '0;
        for (n = 0; n < 4 && cpu_rvalid !== 1'b1; n++) cyc();
        if (n == 4) begin
            bad_count++;
            conclude();
        end else begin
            cmp(cpu_rdata & m, e);
            cyc();
        end
    endtask : rd

    // Repeated superframes, parity calculation all zero
    task automatic fr(input logic [7:0] v5, input logic [7:0] z7, input int n);
        for (int i = 0; i < n; i++) i_bus.send(v5, z7, 2'h0);
    endtask : fr

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge mclk);
        #1 rst = 1'b0;
        rd(10'h047, 8'h00);
        rd(10'h3FF, 8'h00);
        wr(10'h047, 8'h23);
        rd(10'h047, 8'h23);
        cmp({5'h00, tx_label}, 8'h03);
        wr(10'h051, 8'hFF);
        rd(10'h051, 8'h00);
        wr(10'h049, 8'h04);
        rd(10'h049, 8'h04);
        foreach (rows[i]) begin
            fr(rows[i].v5, 8'h00, 1);
            rd(rows[i].addr, rows[i].exp);
        end
        rd(10'h055, 8'h04);
        rd(10'h055, 8'h00);
        // Mismatch runs, one broken run in the middle
        fr(8'h04, 8'h00, 1);
        fr(8'h06, 8'h00, 4);
        rd(10'h051, 8'h00);
        fr(8'h06, 8'h00, 1);
        rd(10'h051, 8'h02);
        fr(8'h04, 8'h00, 4);
        fr(8'h06, 8'h00, 1);
        fr(8'h04, 8'h00, 4);
        rd(10'h051, 8'h02);
        fr(8'h04, 8'h00, 1);
        rd(10'h051, 8'h00);
        fr(8'h02, 8'h00, 5);
        rd(10'h051, 8'h00);
        wr(10'h047, 8'h13);
        fr(8'h0C, 8'h00, 5);
        rd(10'h051, 8'h00);
        // Single-bit remote defect, short then long run
        fr(8'h05, 8'h00, 4);
        rd(10'h051, 8'h00);
        fr(8'h05, 8'h00, 1);
        rd(10'h051, 8'h01);
        wr(10'h01E, 8'h01);
        fr(8'h04, 8'h00, 9);
        rd(10'h051, 8'h01);
        fr(8'h04, 8'h00, 1);
        rd(10'h051, 8'h00);
        signal_fail_input = 1'b1;
        repeat (3) cyc();
        fr(8'h05, 8'h00, 10);
        rd(10'h051, 8'h00, 8'h01);
        signal_fail_input = 1'b0;
        repeat (3) cyc();
        // Enhanced codes, received bit 8 set throughout
        foreach (erdi[i]) begin
            fr(8'h05, erdi[i].v5, 10);
            rd(erdi[i].addr, erdi[i].exp);
        end
        rd(10'h051, 8'h00, 8'h01);
        // Far end fail indication and yellow forwarding
        byte_sync_mode = 1'b1;
        fr(8'h14, 8'h00, 9);
        rd(10'h051, 8'h00, 8'h08);
        fr(8'h14, 8'h00, 1);
        rd(10'h051, 8'h08, 8'h08);
        cmp({7'h00, rfi_yellow}, 8'h01);
        byte_sync_mode = 1'b0;
        repeat (2) cyc();
        cmp({7'h00, rfi_yellow}, 8'h00);
        // Parity counting per bit, then per block, then remote errors
        fr(8'hC4, 8'h00, 1);
        wr(10'h007, 8'h20);
        fr(8'hC4, 8'h00, 1);
        rd(10'h066, 8'h03);
        rd(10'h067, 8'h00);
        fr(8'h24, 8'h00, 2);
        rd(10'h068, 8'h02);
        perf_tick = 1'b1;
        repeat (4) cyc();
        perf_tick = 1'b0;
        rd(10'h059, 8'h0F);
        rd(10'h05A, 8'h07);
        rd(10'h05D, 8'h00);
        rd(10'h06E, 8'h03);
        rd(10'h066, 8'h00);
        rd(10'h070, 8'h02);
        // Saturate the parity counter
        wr(10'h007, 8'h00);
        fr(8'hC4, 8'h00, 2048);
        rd(10'h066, 8'hFF);
        rd(10'h067, 8'h0F);
        rd(10'h051, 8'h40, 8'h40);
        // Second reset in mid-run
        rst = 1'b1;
        cyc();
        rst = 1'b0;
        rd(10'h051, 8'h00);
        rd(10'h047, 8'h00);
        cmp({5'h00, tx_label}, 8'h00);
        conclude();
    end
endmodule : testbench
